// ==== port_mux_pkg.sv ====
// Constants, register map and carrier types for the port pin mux.
// Assumes a word-addressed Avalon-MM slave: the address is the register index.
package port_mux_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_UPPER_DATA = 32'hfffff001;
  localparam logic [31:0] IDX_UPPER_DIR = 32'hfffff004;
  localparam logic [31:0] IDX_UPPER_FUNC = 32'hfffff005;
  localparam logic [31:0] IDX_UPPER_PULLUP = 32'hfffff00d;
  localparam logic [31:0] IDX_LOWER_DATA = 32'hfffff012;
  localparam logic [31:0] IDX_LOWER_DIR = 32'hfffff014;
  localparam logic [31:0] IDX_LOWER_FUNC = 32'hfffff015;
  localparam logic [31:0] IDX_LOWER_TIMER = 32'hfffff016;
  localparam logic [31:0] IDX_LOWER_PULLUP = 32'hfffff01c;
  localparam logic [31:0] IDX_BUS_STATUS = 32'hfffff0f0;

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_UPPER_DATA = 8'h00;
  localparam logic [7:0] RST_UPPER_DIR = 8'h00;
  localparam logic [7:0] RST_UPPER_FUNC = 8'h00;
  localparam logic [7:0] RST_UPPER_PULLUP = 8'h00;
  localparam logic [7:0] RST_LOWER_DATA = 8'hff;
  localparam logic [7:0] RST_LOWER_DIR = 8'h00;
  localparam logic [7:0] RST_LOWER_FUNC = 8'h00;
  localparam logic [7:0] RST_LOWER_TIMER = 8'h00;
  localparam logic [7:0] RST_LOWER_PULLUP = 8'h00;
  localparam int STATUS_MODE_BIT = 0;
  localparam int STATUS_VALID_BIT = 1;

  // ----------------------------------------------------------------
  // Timing: edges after reset release before the strap is trusted
  // ----------------------------------------------------------------
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // Bus mode taken from the strap
  typedef enum logic {
    BUS_SEPARATE,
    BUS_MULTIPLEXED
  } bus_mode_t;

  // Drive bundle for one 8-bit port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [31:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_t;

endpackage

// ==== port_pin_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels.
// Assumes the sampled pins are quasi-static compared to the clock.
`timescale 1ns/1ps
`default_nettype none
module port_pin_sync #(
  parameter int WIDTH = 17
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Two stages, first read only by the second
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;

endmodule
`default_nettype wire

// ==== port_mux.sv ====
// Pin logic for an upper and a lower 8-bit port with bus and timer muxing.
// Assumes a word-addressed Avalon-MM master, a bus controller on this clock
// and pads that resolve out/oe into pin levels.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module port_mux (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire port_mux_pkg::avs_req_t i_avs,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic [7:0] i_upper_pin_in,
  output port_mux_pkg::pin_drive_t o_upper_drive,
  output logic [7:0] o_upper_pullup,
  input wire logic [7:0] i_lower_pin_in,
  output port_mux_pkg::pin_drive_t o_lower_drive,
  output logic [7:0] o_lower_pullup,
  input wire logic i_strap_pin,
  input wire logic [23:0] i_bus_addr,
  input wire logic [15:8] i_bus_wdata,
  input wire logic i_bus_data_oe,
  input wire logic i_bus_addr_phase,
  output logic [15:8] o_bus_rdata,
  output logic o_bus_mode_mux,
  output logic [7:0] o_timer_in
);
  import port_mux_pkg::*;

  // ----------------------------------------------------------------
  // Synchronised pins
  // ----------------------------------------------------------------
  logic [16:0] pin_sync;
  logic [7:0] upper_pin_s;
  logic [7:0] lower_pin_s;
  logic strap_s;

  port_pin_sync #(
    .WIDTH(17)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_async({i_strap_pin, i_lower_pin_in, i_upper_pin_in}),
    .o_sync(pin_sync)
  );

  assign upper_pin_s = pin_sync[7:0];
  assign lower_pin_s = pin_sync[15:8];
  assign strap_s = pin_sync[16];

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_cnt_ff;
  logic strap_done_ff;
  bus_mode_t bus_mode_ff;

  // Wait for the synchroniser to fill, then latch the strap once
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      strap_cnt_ff <= 2'h0;
      strap_done_ff <= 1'b0;
      bus_mode_ff <= BUS_SEPARATE;
    end else if (!strap_done_ff) begin
      if (strap_cnt_ff == STRAP_SETTLE) begin
        strap_done_ff <= 1'b1;
        bus_mode_ff <= strap_s ? BUS_MULTIPLEXED : BUS_SEPARATE;
      end else begin
        strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] upper_data_ff;
  logic [7:0] upper_dir_ff;
  logic [7:0] upper_func_ff;
  logic [7:0] upper_pullup_ff;
  logic [7:0] lower_data_ff;
  logic [7:0] lower_dir_ff;
  logic [7:0] lower_func_ff;
  logic [7:0] lower_timer_ff;
  logic [7:0] lower_pullup_ff;
  logic wait_ff;
  logic [31:0] readdata_ff;
  logic req;
  logic wr_take;
  logic [7:0] wbyte;

  assign req = i_avs.read | i_avs.write;
  assign wr_take = i_avs.write & ~wait_ff & i_avs.byteenable[0];
  assign wbyte = i_avs.writedata[7:0];

  // Upper port registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      upper_data_ff <= RST_UPPER_DATA;
      upper_dir_ff <= RST_UPPER_DIR;
      upper_func_ff <= RST_UPPER_FUNC;
      upper_pullup_ff <= RST_UPPER_PULLUP;
    end else if (wr_take) begin
      case (i_avs.address)
        IDX_UPPER_DATA: upper_data_ff <= wbyte;
        IDX_UPPER_DIR: upper_dir_ff <= wbyte;
        IDX_UPPER_FUNC: upper_func_ff <= wbyte;
        IDX_UPPER_PULLUP: upper_pullup_ff <= wbyte;
        default: ;
      endcase
    end
  end

  // Lower port registers
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      lower_data_ff <= RST_LOWER_DATA;
      lower_dir_ff <= RST_LOWER_DIR;
      lower_func_ff <= RST_LOWER_FUNC;
      lower_timer_ff <= RST_LOWER_TIMER;
      lower_pullup_ff <= RST_LOWER_PULLUP;
    end else if (wr_take) begin
      case (i_avs.address)
        IDX_LOWER_DATA: lower_data_ff <= wbyte;
        IDX_LOWER_DIR: lower_dir_ff <= wbyte;
        IDX_LOWER_FUNC: lower_func_ff <= wbyte;
        IDX_LOWER_TIMER: lower_timer_ff <= wbyte;
        IDX_LOWER_PULLUP: lower_pullup_ff <= wbyte;
        default: ;
      endcase
    end
  end

  // Port data read view: latch for GPIO outputs, pin level otherwise
  logic [7:0] upper_view;
  logic [7:0] lower_view;
  logic [7:0] upper_is_out;
  logic [7:0] lower_is_out;
  logic [7:0] status_view;

  assign upper_is_out = ~upper_func_ff & upper_dir_ff;
  assign lower_is_out = ~lower_func_ff & lower_dir_ff;
  assign upper_view = (upper_is_out & upper_data_ff) |
                      (~upper_is_out & upper_pin_s);
  assign lower_view = (lower_is_out & lower_data_ff) |
                      (~lower_is_out & lower_pin_s);

  always_comb begin
    status_view = 8'h00;
    status_view[STATUS_MODE_BIT] = (bus_mode_ff == BUS_MULTIPLEXED);
    status_view[STATUS_VALID_BIT] = strap_done_ff;
  end

  // Avalon handshake: one wait state, read data registered with it
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      wait_ff <= 1'b1;
      readdata_ff <= 32'h00000000;
    end else if (req && wait_ff) begin
      wait_ff <= 1'b0;
      readdata_ff <= 32'h00000000;
      if (i_avs.read) begin
        case (i_avs.address)
          IDX_UPPER_DATA: readdata_ff[7:0] <= upper_view;
          IDX_UPPER_DIR: readdata_ff[7:0] <= upper_dir_ff;
          IDX_UPPER_FUNC: readdata_ff[7:0] <= upper_func_ff;
          IDX_UPPER_PULLUP: readdata_ff[7:0] <= upper_pullup_ff;
          IDX_LOWER_DATA: readdata_ff[7:0] <= lower_view;
          IDX_LOWER_DIR: readdata_ff[7:0] <= lower_dir_ff;
          IDX_LOWER_FUNC: readdata_ff[7:0] <= lower_func_ff;
          IDX_LOWER_TIMER: readdata_ff[7:0] <= lower_timer_ff;
          IDX_LOWER_PULLUP: readdata_ff[7:0] <= lower_pullup_ff;
          IDX_BUS_STATUS: readdata_ff[7:0] <= status_view;
          default: readdata_ff[7:0] <= 8'h00;
        endcase
      end
    end else begin
      wait_ff <= 1'b1;
    end
  end

  assign o_avs_waitrequest = wait_ff;
  assign o_avs_readdata = readdata_ff;

  // ----------------------------------------------------------------
  // Per-pin function decode
  // ----------------------------------------------------------------
  logic [7:0] nxt_upper_out;
  logic [7:0] nxt_upper_oe;
  logic [7:0] nxt_lower_out;
  logic [7:0] nxt_lower_oe;
  logic [7:0] nxt_bus_rdata;
  logic [7:0] nxt_timer;
  logic mux_addr;

  // Address phase only exists in multiplexed mode
  assign mux_addr = (bus_mode_ff == BUS_MULTIPLEXED) & i_bus_addr_phase;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // Upper pin: {function, direction}
      always_comb begin
        nxt_upper_out[gi] = 1'b0;
        nxt_upper_oe[gi] = 1'b0;
        nxt_bus_rdata[gi] = 1'b0;
        case ({upper_func_ff[gi], upper_dir_ff[gi]})
          2'h0: ;
          2'h1: begin
            nxt_upper_out[gi] = upper_data_ff[gi];
            nxt_upper_oe[gi] = 1'b1;
          end
          2'h2: begin
            nxt_upper_out[gi] = mux_addr ? i_bus_addr[8+gi]
                                         : i_bus_wdata[8+gi];
            nxt_upper_oe[gi] = mux_addr | i_bus_data_oe;
            nxt_bus_rdata[gi] = upper_pin_s[gi];
          end
          2'h3: begin
            nxt_upper_out[gi] = i_bus_addr[8+gi];
            nxt_upper_oe[gi] = 1'b1;
          end
          default: ;
        endcase
      end

      // Lower pin: {function, timer select, direction}, strap unused
      always_comb begin
        nxt_lower_out[gi] = 1'b0;
        nxt_lower_oe[gi] = 1'b0;
        nxt_timer[gi] = 1'b0;
        case ({lower_func_ff[gi], lower_timer_ff[gi], lower_dir_ff[gi]})
          3'h0, 3'h2: ;
          3'h1, 3'h3: begin
            nxt_lower_out[gi] = lower_data_ff[gi];
            nxt_lower_oe[gi] = 1'b1;
          end
          3'h4: begin
            nxt_lower_out[gi] = i_bus_addr[gi];
            nxt_lower_oe[gi] = 1'b1;
          end
          3'h5: begin
            nxt_lower_out[gi] = i_bus_addr[16+gi];
            nxt_lower_oe[gi] = 1'b1;
          end
          3'h6: nxt_timer[gi] = lower_pin_s[gi];
          default: ;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  pin_drive_t upper_drive_ff;
  pin_drive_t lower_drive_ff;
  logic [7:0] bus_rdata_ff;
  logic [7:0] timer_ff;

  // Pin drives and captured inputs
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      upper_drive_ff <= '0;
      lower_drive_ff <= '0;
      bus_rdata_ff <= 8'h00;
      timer_ff <= 8'h00;
    end else begin
      upper_drive_ff <= '{out: nxt_upper_out, oe: nxt_upper_oe};
      lower_drive_ff <= '{out: nxt_lower_out, oe: nxt_lower_oe};
      bus_rdata_ff <= nxt_bus_rdata;
      timer_ff <= nxt_timer;
    end
  end

  assign o_upper_drive = upper_drive_ff;
  assign o_lower_drive = lower_drive_ff;
  assign o_upper_pullup = upper_pullup_ff;
  assign o_lower_pullup = lower_pullup_ff;
  assign o_bus_rdata = bus_rdata_ff;
  assign o_timer_in = timer_ff;
  assign o_bus_mode_mux = (bus_mode_ff == BUS_MULTIPLEXED);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_upper_gpio_dir: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ##1 ((o_upper_drive.oe & ~$past(upper_func_ff)) ==
         ($past(upper_dir_ff) & ~$past(upper_func_ff))))
    else $error("upper gpio enable mismatch");

  a_upper_addr_out: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ##1 ((o_upper_drive.out & $past(upper_func_ff & upper_dir_ff)) ==
         ($past(i_bus_addr[15:8]) & $past(upper_func_ff & upper_dir_ff))))
    else $error("upper address bits wrong");

  a_sep_data_bus: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (bus_mode_ff == BUS_SEPARATE && upper_func_ff[0] && !upper_dir_ff[0])
    |=> (o_upper_drive.out[0] == $past(i_bus_wdata[8]) &&
         o_upper_drive.oe[0] == $past(i_bus_data_oe)))
    else $error("separate data lane wrong");

  a_mux_addr_phase: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (bus_mode_ff == BUS_MULTIPLEXED && i_bus_addr_phase &&
     upper_func_ff[0] && !upper_dir_ff[0])
    |=> (o_upper_drive.oe[0] && o_upper_drive.out[0] == $past(i_bus_addr[8])))
    else $error("multiplexed address phase wrong");

  a_timer_route: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    ##1 (o_timer_in == $past(lower_pin_s & lower_func_ff &
                             lower_timer_ff & ~lower_dir_ff)))
    else $error("timer input routing wrong");

  a_lower_low_addr: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (lower_func_ff[3] && !lower_timer_ff[3] && !lower_dir_ff[3])
    |=> (o_lower_drive.oe[3] && o_lower_drive.out[3] == $past(i_bus_addr[3])))
    else $error("lower address 7-0 wrong");

  a_lower_high_addr: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (lower_func_ff[5] && !lower_timer_ff[5] && lower_dir_ff[5])
    |=> (o_lower_drive.oe[5] &&
         o_lower_drive.out[5] == $past(i_bus_addr[21])))
    else $error("lower address 23-16 wrong");

  a_lower_gpio_dir: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (!lower_func_ff[1]) |=> (o_lower_drive.oe[1] == $past(lower_dir_ff[1])))
    else $error("lower gpio direction wrong");

  a_bus_answer: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (req && wait_ff) |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
    else $error("bus answer timing wrong");

  a_lower_readback: assert property (
    @(posedge i_clk_sys) disable iff (!i_rstn)
    (i_avs.read && wait_ff && i_avs.address == IDX_LOWER_DATA)
    |=> (o_avs_readdata[7:0] == $past(lower_view)))
    else $error("lower data readback wrong");

endmodule
`default_nettype wire

// ==== port_pad_model.sv ====
// Pad model for both ports: resolves device drive, far-side drive and pulls.
// Assumes the bench supplies far-side levels and which bits it drives.
`timescale 1ns/1ps
`default_nettype none
module port_pad_model (
  input wire logic i_clk_sys,
  input wire port_mux_pkg::pin_drive_t i_upper_drive,
  input wire port_mux_pkg::pin_drive_t i_lower_drive,
  input wire logic [7:0] i_upper_pullup,
  input wire logic [7:0] i_lower_pullup,
  input wire logic [15:0] i_ext_level,
  input wire logic [15:0] i_ext_en,
  output logic [7:0] o_upper_pin,
  output logic [7:0] o_lower_pin
);
  import port_mux_pkg::*;
  logic [15:0] float_ff = 16'h5aa5;
  logic [15:0] oe;
  logic [15:0] out;
  logic [15:0] pull;
  logic [15:0] level;
  // Undriven, unpulled lines change every cycle, never keep a stale value
  always @(posedge i_clk_sys) begin
    float_ff <= ~float_ff;
  end
  assign oe = {i_upper_drive.oe, i_lower_drive.oe};
  assign out = {i_upper_drive.out, i_lower_drive.out};
  assign pull = {i_upper_pullup, i_lower_pullup};
  // Device drive first, then far side, then pull-up, else floating
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (oe[i]) level[i] = out[i];
      else if (i_ext_en[i]) level[i] = i_ext_level[i];
      else if (pull[i]) level[i] = 1'b1;
      else level[i] = float_ff[i];
    end
  end
  assign o_upper_pin = level[15:8];
  assign o_lower_pin = level[7:0];
endmodule
`default_nettype wire

// ==== port_mux_tb.sv ====
// Self-checking bench for the port pin mux with random register setups.
// Assumes the pad model above and the one-wait-state register bus.
`timescale 1ns/1ps
`default_nettype none
module port_mux_tb;
  import port_mux_pkg::*;
  logic clk_sys, rst_n, strap, mode, bus_oe, bus_phase;
  avs_req_t avs;
  logic [31:0] rdata;
  logic waitreq, mode_mux;
  logic [7:0] up_pin, lo_pin, up_pull, lo_pull, timer_in, rv [9];
  logic [15:8] bus_wdata, bus_rdata;
  pin_drive_t up_drv, lo_drv, eu, el;
  logic [23:0] bus_addr;
  logic [15:0] ext_level, ext_en;
  logic [31:0] idx [9];
  logic [7:0] v, pu, pl;
  int err_total, checks_done;
  logic be_on;

  port_mux u_dut (.i_clk_sys(clk_sys), .i_rstn(rst_n), .i_avs(avs),
    .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .i_upper_pin_in(up_pin), .o_upper_drive(up_drv), .o_upper_pullup(up_pull),
    .i_lower_pin_in(lo_pin), .o_lower_drive(lo_drv), .o_lower_pullup(lo_pull),
    .i_strap_pin(strap), .i_bus_addr(bus_addr), .i_bus_wdata(bus_wdata),
    .i_bus_data_oe(bus_oe), .i_bus_addr_phase(bus_phase),
    .o_bus_rdata(bus_rdata), .o_bus_mode_mux(mode_mux), .o_timer_in(timer_in));
  port_pad_model u_pads (.i_clk_sys(clk_sys), .i_upper_drive(up_drv),
    .i_lower_drive(lo_drv), .i_upper_pullup(up_pull), .i_lower_pullup(lo_pull),
    .i_ext_level(ext_level), .i_ext_en(ext_en), .o_upper_pin(up_pin),
    .o_lower_pin(lo_pin));

  // 50 MHz clock
  always #10 clk_sys = ~clk_sys;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs.address <= a;
    avs.read <= ~wr;
    avs.write <= wr;
    avs.writedata <= {24'h0, d};
    avs.byteenable <= {3'h0, be_on};
    do begin
      @(posedge clk_sys);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    v = rdata[7:0];
    avs.read <= 1'b0;
    avs.write <= 1'b0;
    if (n >= 50) begin
      err_total++;
      $display("MISMATCH %0t bus timeout", $time);
      stop_test();
    end
  endtask

  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    mode = s;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask

  // Expected upper drive from function, direction and latch
  function automatic pin_drive_t exp_up(input logic [7:0] f, d, lat);
    pin_drive_t r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      case ({f[i], d[i]})
        2'b01: r.out[i] = lat[i];
        2'b10: r.out[i] = (mode && bus_phase) ? bus_addr[8+i] : bus_wdata[8+i];
        2'b11: r.out[i] = bus_addr[8+i];
        default: r.out[i] = 1'b0;
      endcase
      r.oe[i] = d[i] | (f[i] & (bus_oe | (mode & bus_phase)));
    end
    return r;
  endfunction

  // Expected lower drive from function, timer select, direction and latch
  function automatic pin_drive_t exp_lo(input logic [7:0] f, t, d, lat);
    pin_drive_t r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      case ({f[i], t[i], d[i]})
        3'b001, 3'b011: r.out[i] = lat[i];
        3'b100: r.out[i] = bus_addr[i];
        3'b101: r.out[i] = bus_addr[16+i];
        default: r.out[i] = 1'b0;
      endcase
      r.oe[i] = (~f[i] & d[i]) | (f[i] & ~t[i]);
    end
    return r;
  endfunction

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    strap = 1'b0;
    avs = '0;
    bus_addr = '0;
    bus_wdata = '0;
    bus_oe = 1'b0;
    bus_phase = 1'b0;
    ext_level = '0;
    ext_en = 16'hffff;
    err_total = 0;
    checks_done = 0;
    be_on = 1'b1;
    idx = '{IDX_UPPER_DATA, IDX_UPPER_DIR, IDX_UPPER_FUNC, IDX_UPPER_PULLUP,
      IDX_LOWER_DATA, IDX_LOWER_DIR, IDX_LOWER_FUNC, IDX_LOWER_TIMER,
      IDX_LOWER_PULLUP};
    void'($urandom(32'h7dae));
    for (int m = 0; m < 2; m++) begin
      do_reset(m[0]);
      chk(up_drv.oe, 8'h00, "upper oe reset");
      chk(lo_drv.oe, 8'h00, "lower oe reset");
      chk({7'h0, mode_mux}, {7'h0, mode}, "mode");
      xfer(1'b0, IDX_BUS_STATUS, 8'h00);
      chk(v, {6'h0, 1'b1, mode}, "status");
      for (int k = 1; k < 9; k++) begin
        if (k != 4) xfer(1'b0, idx[k], 8'h00);
        if (k != 4) chk(v, 8'h00, "reset value");
      end
      xfer(1'b1, IDX_LOWER_DIR, 8'hff);
      xfer(1'b1, IDX_UPPER_DIR, 8'hff);
      repeat (3) @(posedge clk_sys);
      chk(lo_drv.out, 8'hff, "lower latch reset");
      xfer(1'b0, IDX_LOWER_DATA, 8'h00);
      chk(v, 8'hff, "lower data reset");
      xfer(1'b0, IDX_UPPER_DATA, 8'h00);
      chk(v, 8'h00, "upper data reset");
      $display("reset test done, mode %0d", mode);
      for (int it = 0; it < 40; it++) begin
        for (int k = 0; k < 9; k++) rv[k] = 8'($urandom);
        if (it < 4) begin
          rv[2] = 8'hff;
          rv[6] = 8'hff;
          rv[7] = it[0] ? 8'hff : 8'h00;
          rv[5] = it[1] ? 8'hff : 8'h00;
          rv[1] = rv[5];
        end
        bus_addr <= 24'($urandom);
        bus_wdata <= 8'($urandom);
        bus_oe <= 1'($urandom);
        bus_phase <= 1'($urandom);
        ext_level <= 16'($urandom);
        for (int k = 0; k < 9; k++) xfer(1'b1, idx[k], rv[k]);
        repeat (6) @(posedge clk_sys);
        eu = exp_up(rv[2], rv[1], rv[0]);
        el = exp_lo(rv[6], rv[7], rv[5], rv[4]);
        pu = (eu.oe & eu.out) | (~eu.oe & ext_level[15:8]);
        pl = (el.oe & el.out) | (~el.oe & ext_level[7:0]);
        chk(up_drv.oe, eu.oe, "upper oe");
        chk(up_drv.out & up_drv.oe, eu.out & eu.oe, "upper out");
        chk(lo_drv.oe, el.oe, "lower oe");
        chk(lo_drv.out & lo_drv.oe, el.out & el.oe, "lower out");
        chk(timer_in, rv[6] & rv[7] & ~rv[5] & pl, "timer");
        chk(bus_rdata, rv[2] & ~rv[1] & pu, "bus rdata");
        chk(up_pull, rv[3], "upper pull");
        chk(lo_pull, rv[8], "lower pull");
        for (int k = 1; k < 9; k++) begin
          if (k != 4) xfer(1'b0, idx[k], 8'h00);
          if (k != 4) chk(v, rv[k], "readback");
        end
        xfer(1'b0, IDX_UPPER_DATA, 8'h00);
        chk(v, (~rv[2] & rv[1] & rv[0]) | ~(~rv[2] & rv[1]) & pu, "udata");
        xfer(1'b0, IDX_LOWER_DATA, 8'h00);
        chk(v, (~rv[6] & rv[5] & rv[4]) | ~(~rv[6] & rv[5]) & pl, "ldata");
      end
      $display("random test done");
      ext_en <= 16'h0000;
      for (int k = 1; k < 9; k++) xfer(1'b1, idx[k], (k == 3 || k == 8) ? 8'hff : 8'h00);
      repeat (6) @(posedge clk_sys);
      xfer(1'b0, IDX_UPPER_DATA, 8'h00);
      chk(v, 8'hff, "upper pulled");
      xfer(1'b0, IDX_LOWER_DATA, 8'h00);
      chk(v, 8'hff, "lower pulled");
      ext_en <= 16'hffff;
      $display("pull-up test done");
    end
    xfer(1'b1, 32'hfffff0e0, 8'h5a);
    xfer(1'b0, 32'hfffff0e0, 8'h00);
    chk(v, 8'h00, "unmapped");
    // Write with the low byte lane off must leave the pull-ups alone
    be_on = 1'b0;
    xfer(1'b1, IDX_UPPER_PULLUP, 8'h00);
    be_on = 1'b1;
    xfer(1'b0, IDX_UPPER_PULLUP, 8'h00);
    chk(v, 8'hff, "byte lane off");
    chk(rdata[31:24] | rdata[23:16] | rdata[15:8], 8'h00, "high bytes");
    $display("unmapped test done");
    stop_test();
  end
endmodule
`default_nettype wire
